// file: pbmux_pkg.sv
// package for the port b alternate-function mux: pin positions, reset values,
// pin-side and override carrier structs.
// assumes nothing of its surroundings beyond a systemverilog compiler.
package pbmux_pkg;
   localparam int   PBMUX_W      = 8;      // pins in port b
   localparam int   PIN_MISO     = 0;      // master-in / power stage 2a
   localparam int   PIN_MOSI     = 1;      // master-out / power stage 2b
   localparam int   PIN_IRQ1     = 2;      // external irq 1
   localparam int   PIN_IRQ2     = 5;      // external irq 2
   localparam int   PIN_PS1B     = 6;      // power stage 1b
   localparam int   PIN_SCK      = 7;      // serial clock / power stage 0b
   localparam logic [7:0] RST_ZERO8 = 8'h00;  // reset value of pin controls
   localparam logic       RST_BIT   = 1'b0;   // reset value of single bits

   // spi control as seen by the mux
   typedef struct packed {
      logic spi_enable_bit;       // spi enabled
      logic spi_master_select;    // master when set
      logic spi_pin_relocate;     // spi moved away from port b
   } pbmux_spi_s;

   // power stage controller outputs and their enables
   typedef struct packed {
      logic power_stage_en_0b;
      logic power_stage_out_0b;
      logic power_stage_en_1b;
      logic power_stage_out_1b;
      logic power_stage_en_2b;
      logic power_stage_out_2b;
      logic power_stage_en_2a;
      logic power_stage_out_2a;
   } pbmux_psc_s;

   // per-pin override set for one pin
   typedef struct packed {
      logic pullup_override_en;
      logic pullup_override_val;
      logic direction_override_en;
      logic direction_override_val;
      logic value_override_en;
      logic value_override_val;
      logic input_en_override_en;
      logic input_en_override_val;
   } pbmux_ovr_s;

   // pin controls toward the pads
   typedef struct packed {
      logic [7:0] drive_en;   // output driver enable
      logic [7:0] drive_val;  // output level
      logic [7:0] pullup_on;  // pull-up enable
      logic [7:0] input_on;   // digital input buffer enable
   } pbmux_pad_s;
endpackage : pbmux_pkg

// file: pbmux_pin.sv
// one generic port pin: applies an override set to the port register bits.
// assumes register bits and overrides come from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module pbmux_pin (
   input  wire logic              dir_bit,          // direction register bit
   input  wire logic              out_bit,          // port output register bit
   input  wire logic              global_pullup_off, // disables pull-ups not overridden
   input  wire logic              sleep_clamp,      // sleep clamps inputs
   input  wire pbmux_pkg::pbmux_ovr_s ovr,          // override set
   output logic                   drive_en,         // driver enable
   output logic                   drive_val,        // driven level
   output logic                   pullup_on,        // pull-up enable
   output logic                   input_on          // input buffer enable
);
   import pbmux_pkg::*;
   // combine register bits and overrides
   always_comb begin
      drive_en = ovr.direction_override_en ? ovr.direction_override_val : dir_bit; // [R21]
      drive_val = ovr.value_override_en ? ovr.value_override_val : out_bit;
      // pull-up only as input with output bit high, unless overridden
      if (ovr.pullup_override_en) begin
         pullup_on = ovr.pullup_override_val;                                    // [R20]
      end else begin
         pullup_on = !dir_bit && out_bit && !global_pullup_off;                  // [R23]
      end
      input_on = ovr.input_en_override_en ? ovr.input_en_override_val
                                          : !sleep_clamp;                        // [R22]
   end
endmodule : pbmux_pin
`default_nettype wire

// file: pbmux_sync.sv
// three-stage synchroniser bank for pin inputs with change qualification.
// assumes the inputs are asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module pbmux_sync #(
   parameter int W = 8                      // bits synchronised
) (
   input  wire logic         core_clk,      // core clock
   input  wire logic         resetn,        // synchronous reset, active low
   input  wire logic [W-1:0] async_in,      // raw pin levels
   output logic      [W-1:0] sync_out       // qualified level
);
   import pbmux_pkg::*;
   logic [W-1:0] s1_r, s2_r, s3_r, q_r;     // stages and qualified value
   logic [W-1:0] s1_nxt, s2_nxt, s3_nxt, q_nxt;
   // next-state: shift, accept a change when stages two and three agree
   always_comb begin
      s1_nxt = async_in;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      for (int i = 0; i < W; i++) begin
         q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
      end
   end
   // registers only
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r  <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         q_r  <= q_nxt;
      end
   end
   assign sync_out = q_r;
endmodule : pbmux_sync
`default_nettype wire

// file: pbmux_top.sv
// port b alternate-function mux: spi, power stage, irq and analog overrides
// on eight pins, with registered pad controls and synchronised pin inputs.
// assumes port registers, peripheral enables and internal reset are on core_clk.
//
// Overview of operation
// R1: spi slave forces serial clock pin input
// R2: spi master: serial clock direction from register
// R3: forced serial clock keeps output-bit pull-up
// R4: spi slave forces master-out pin input
// R5: spi master: master-out direction from register
// R6: forced master-out pull-up uses output bit, global-off
// R7: spi master forces master-in pin input
// R8: spi slave: master-in direction from register
// R9: forced master-in pull-up uses output bit, global-off
// R10: pin 5 feeds irq 2, input kept
// R11: pin 2 feeds irq 1, input kept
// R12: spi master-out input gated by select, reset
// R13: spi master-in input gated by select, reset
// R14: power stage 1b drives pin 6
// R15: power stage 0b drives pin 7
// R16: power stage 2b, 2a on pins 1, 0
// R17: analog disable bit turns off input buffer
// R18: each pin feeds its pin-change source
// R19: software: analog pins input, pull-up off
// R20: pull-up override sets pull-up directly
// R21: direction override sets driver enable
// R22: input override ignores sleep state
// R23: global pull-up off disables every pull-up
// R24: relocated spi leaves port b pins alone
`timescale 1ns/10ps
`default_nettype none
module pbmux_top (
   input  wire logic                  core_clk,          // i/o clock, 125 MHz
   input  wire logic                  resetn,            // synchronous, active low
   input  wire logic [7:0]            dir_bits,          // port b direction reg
   input  wire logic [7:0]            out_bits,          // port b output reg
   input  wire logic                  global_pullup_off, // global pull-up disable
   input  wire logic                  sleep_clamp,       // sleep input clamp
   input  wire logic                  internal_reset,    // chip internal reset
   input  wire pbmux_pkg::pbmux_spi_s spi_ctl,           // spi mode bits
   input  wire pbmux_pkg::pbmux_psc_s psc,               // power stage outputs
   input  wire logic                  spi_sck_out,       // spi clock as master
   input  wire logic                  spi_mosi_out,      // spi data as master
   input  wire logic                  spi_miso_out,      // spi data as slave
   input  wire logic                  ext_irq_1_enabled, // irq 1 enabled
   input  wire logic                  ext_irq_2_enabled, // irq 2 enabled
   input  wire logic [7:0]            analog_in_disable, // per-pin analog disable
   input  wire logic [7:0]            pin_in,            // pad levels
   output logic      [7:0]            pin_out,           // pad drive level
   output logic      [7:0]            pin_oe,            // pad drive enable
   output logic      [7:0]            pin_pullup,        // pad pull-up enable
   output logic      [7:0]            pin_input_on,      // pad input buffer on
   output logic      [7:0]            pin_change_irq,    // pin-change sources
   output logic                       ext_irq_1,         // irq 1 source
   output logic                       ext_irq_2,         // irq 2 source
   output logic                       spi_sck_in,        // serial clock to spi
   output logic                       spi_mosi_in,       // master-out to spi
   output logic                       spi_miso_in        // master-in to spi
);
   import pbmux_pkg::*;

   logic       spi_on;           // spi owns port b pins
   logic       spi_slave;        // enabled as slave here
   logic       spi_master;       // enabled as master here
   pbmux_ovr_s ovr [PBMUX_W];    // override set per pin
   pbmux_pad_s pad;              // combinational pad controls
   pbmux_pad_s pad_r, pad_nxt;   // registered pad controls
   logic [7:0] pin_sync;         // synchronised pad levels
   logic [7:0] din;              // input gated by buffer enable
   logic [7:0] irq_pc_r, irq_pc_nxt;      // pin-change outputs
   logic [1:0] irq_ext_r, irq_ext_nxt;    // external irq outputs
   logic [2:0] spi_in_r, spi_in_nxt;      // spi inputs: sck, mosi, miso

   // spi role decode; a relocated spi does not touch port b
   always_comb begin
      spi_on     = spi_ctl.spi_enable_bit && !spi_ctl.spi_pin_relocate; // [R24]
      spi_slave  = spi_on && !spi_ctl.spi_master_select;
      spi_master = spi_on && spi_ctl.spi_master_select;
   end

   // override sets for every pin
   always_comb begin
      for (int i = 0; i < PBMUX_W; i++) begin
         ovr[i] = '0;
         // analog disable turns the input buffer off
         ovr[i].input_en_override_en = analog_in_disable[i];      // [R17]
         ovr[i].input_en_override_val = RST_BIT;
      end
      // serial clock pin / power stage 0b
      if (psc.power_stage_en_0b) begin
         ovr[PIN_SCK].direction_override_en  = 1'b1;                // [R15]
         ovr[PIN_SCK].direction_override_val = 1'b1;
         ovr[PIN_SCK].value_override_en      = 1'b1;
         ovr[PIN_SCK].value_override_val     = psc.power_stage_out_0b; // [R15]
      end else if (spi_slave) begin
         ovr[PIN_SCK].direction_override_en  = 1'b1;                // [R1]
         ovr[PIN_SCK].direction_override_val = 1'b0;
         ovr[PIN_SCK].pullup_override_en     = 1'b1;
         ovr[PIN_SCK].pullup_override_val    = out_bits[PIN_SCK]
                                               && !global_pullup_off; // [R3]
      end else if (spi_master) begin
         ovr[PIN_SCK].value_override_en  = 1'b1;                    // [R2]
         ovr[PIN_SCK].value_override_val = spi_sck_out;
      end
      // power stage 1b
      if (psc.power_stage_en_1b) begin
         ovr[PIN_PS1B].direction_override_en  = 1'b1;               // [R14]
         ovr[PIN_PS1B].direction_override_val = 1'b1;
         ovr[PIN_PS1B].value_override_en      = 1'b1;
         ovr[PIN_PS1B].value_override_val     = psc.power_stage_out_1b; // [R14]
      end
      // irq pins keep the input buffer on while enabled
      if (ext_irq_2_enabled) begin
         ovr[PIN_IRQ2].input_en_override_en  = 1'b1;                // [R10]
         ovr[PIN_IRQ2].input_en_override_val = 1'b1;
      end
      if (ext_irq_1_enabled) begin
         ovr[PIN_IRQ1].input_en_override_en  = 1'b1;                // [R11]
         ovr[PIN_IRQ1].input_en_override_val = 1'b1;
      end
      // master-out pin / power stage 2b
      if (psc.power_stage_en_2b) begin
         ovr[PIN_MOSI].direction_override_en  = 1'b1;               // [R16]
         ovr[PIN_MOSI].direction_override_val = 1'b1;
         ovr[PIN_MOSI].value_override_en      = 1'b1;
         ovr[PIN_MOSI].value_override_val     = psc.power_stage_out_2b;
      end else if (spi_slave) begin
         ovr[PIN_MOSI].direction_override_en  = 1'b1;               // [R4]
         ovr[PIN_MOSI].direction_override_val = 1'b0;
         ovr[PIN_MOSI].pullup_override_en     = 1'b1;
         ovr[PIN_MOSI].pullup_override_val    = out_bits[PIN_MOSI]
                                                && !global_pullup_off; // [R6]
      end else if (spi_master) begin
         ovr[PIN_MOSI].value_override_en  = 1'b1;                   // [R5]
         ovr[PIN_MOSI].value_override_val = spi_mosi_out;
      end
      // master-in pin / power stage 2a
      if (psc.power_stage_en_2a) begin
         ovr[PIN_MISO].direction_override_en  = 1'b1;               // [R16]
         ovr[PIN_MISO].direction_override_val = 1'b1;
         ovr[PIN_MISO].value_override_en      = 1'b1;
         ovr[PIN_MISO].value_override_val     = psc.power_stage_out_2a;
      end else if (spi_master) begin
         ovr[PIN_MISO].direction_override_en  = 1'b1;               // [R7]
         ovr[PIN_MISO].direction_override_val = 1'b0;
         ovr[PIN_MISO].pullup_override_en     = 1'b1;
         ovr[PIN_MISO].pullup_override_val    = out_bits[PIN_MISO]
                                                && !global_pullup_off; // [R9]
      end else if (spi_slave) begin
         ovr[PIN_MISO].value_override_en  = 1'b1;                   // [R8]
         ovr[PIN_MISO].value_override_val = spi_miso_out;
      end
   end

   // one generic pin per bit
   for (genvar g = 0; g < PBMUX_W; g++) begin : g_pin
      pbmux_pin u_pin (
         .dir_bit           (dir_bits[g]),
         .out_bit           (out_bits[g]),
         .global_pullup_off (global_pullup_off),
         .sleep_clamp       (sleep_clamp),
         .ovr               (ovr[g]),
         .drive_en          (pad.drive_en[g]),
         .drive_val         (pad.drive_val[g]),
         .pullup_on         (pad.pullup_on[g]),
         .input_on          (pad.input_on[g])
      );
   end

   // pad levels into the clock domain
   pbmux_sync #(.W(PBMUX_W)) u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // next values of registered outputs
   always_comb begin
      pad_nxt = pad;
      din = pin_sync & pad_r.input_on;
      irq_pc_nxt = din;                                             // [R18]
      irq_ext_nxt = {din[PIN_IRQ2], din[PIN_IRQ1]};                 // [R10] [R11]
      spi_in_nxt[2] = din[PIN_SCK] && !spi_ctl.spi_pin_relocate && !internal_reset;
      spi_in_nxt[1] = din[PIN_MOSI] && !spi_ctl.spi_pin_relocate
                      && !internal_reset;                           // [R12]
      spi_in_nxt[0] = din[PIN_MISO] && !spi_ctl.spi_pin_relocate
                      && !internal_reset;                           // [R13]
   end

   // output registers; pads idle as inputs without pull-up in reset
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pad_r     <= '0;
         irq_pc_r  <= RST_ZERO8;
         irq_ext_r <= '0;
         spi_in_r  <= '0;
      end else begin
         pad_r     <= pad_nxt;
         irq_pc_r  <= irq_pc_nxt;
         irq_ext_r <= irq_ext_nxt;
         spi_in_r  <= spi_in_nxt;
      end
   end

   assign pin_out        = pad_r.drive_val;
   assign pin_oe         = pad_r.drive_en;
   assign pin_pullup     = pad_r.pullup_on;
   assign pin_input_on   = pad_r.input_on;
   assign pin_change_irq = irq_pc_r;
   assign ext_irq_1      = irq_ext_r[0];
   assign ext_irq_2      = irq_ext_r[1];
   assign spi_sck_in     = spi_in_r[2];
   assign spi_mosi_in    = spi_in_r[1];
   assign spi_miso_in    = spi_in_r[0];

   // checks
   property p_slave_sck_in; // [R1]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_slave && !psc.power_stage_en_0b) |=> !pin_oe[PIN_SCK];
   endproperty
   a_slave_sck_in: assert property (p_slave_sck_in) else $error("sck not input as slave"); // [R1]
   property p_master_sck_dir; // [R2]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_master && !psc.power_stage_en_0b)
         |=> pin_oe[PIN_SCK] == $past(dir_bits[PIN_SCK]);
   endproperty
   a_master_sck_dir: assert property (p_master_sck_dir) else $error("sck dir wrong"); // [R2]
   property p_slave_mosi_in; // [R4]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_slave && !psc.power_stage_en_2b) |=> !pin_oe[PIN_MOSI];
   endproperty
   a_slave_mosi_in: assert property (p_slave_mosi_in) else $error("mosi not input"); // [R4]
   property p_master_miso_in; // [R7]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_master && !psc.power_stage_en_2a) |=> !pin_oe[PIN_MISO];
   endproperty
   a_master_miso_in: assert property (p_master_miso_in) else $error("miso not input"); // [R7]
   property p_miso_pullup; // [R9]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_master && !psc.power_stage_en_2a && global_pullup_off)
         |=> !pin_pullup[PIN_MISO];
   endproperty
   a_miso_pullup: assert property (p_miso_pullup) else $error("miso pull-up on"); // [R9]
   property p_ps1b; // [R14]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && psc.power_stage_en_1b)
         |=> pin_oe[PIN_PS1B] && pin_out[PIN_PS1B] == $past(psc.power_stage_out_1b);
   endproperty
   a_ps1b: assert property (p_ps1b) else $error("pin 6 not driven by 1b"); // [R14]
   property p_ps0b; // [R15]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && psc.power_stage_en_0b)
         |=> pin_oe[PIN_SCK] && pin_out[PIN_SCK] == $past(psc.power_stage_out_0b);
   endproperty
   a_ps0b: assert property (p_ps0b) else $error("pin 7 not driven by 0b"); // [R15]
   property p_irq2_input; // [R10]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && ext_irq_2_enabled) |=> pin_input_on[PIN_IRQ2];
   endproperty
   a_irq2_input: assert property (p_irq2_input) else $error("irq2 input off"); // [R10]
   property p_analog_off; // [R17]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && analog_in_disable[PIN_PS1B]) |=> !pin_input_on[PIN_PS1B];
   endproperty
   a_analog_off: assert property (p_analog_off) else $error("input on despite analog"); // [R17]
   property p_reset_gate; // [R12]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && internal_reset) |=> !spi_mosi_in;
   endproperty
   a_reset_gate: assert property (p_reset_gate) else $error("mosi in during reset"); // [R12]
   property p_pud; // [R23]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && global_pullup_off && !spi_on) |=> pin_pullup[PIN_IRQ1] == 1'b0;
   endproperty
   a_pud: assert property (p_pud) else $error("pull-up despite global off"); // [R23]
   // forced serial clock input still takes its pull-up from the output bit
   property p_slave_sck_pullup; // [R3]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_slave && !psc.power_stage_en_0b)
         |=> pin_pullup[PIN_SCK] == ($past(out_bits[PIN_SCK]) && !$past(global_pullup_off));
   endproperty
   a_slave_sck_pullup: assert property (p_slave_sck_pullup) else $error("sck pull-up wrong"); // [R3]
   // master-out direction stays with the register as master
   property p_master_mosi_dir; // [R5]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_master && !psc.power_stage_en_2b)
         |=> pin_oe[PIN_MOSI] == $past(dir_bits[PIN_MOSI]);
   endproperty
   a_master_mosi_dir: assert property (p_master_mosi_dir) else $error("mosi dir wrong"); // [R5]
   // master-in direction stays with the register as slave
   property p_slave_miso_dir; // [R8]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_slave && !psc.power_stage_en_2a)
         |=> pin_oe[PIN_MISO] == $past(dir_bits[PIN_MISO]);
   endproperty
   a_slave_miso_dir: assert property (p_slave_miso_dir) else $error("miso dir wrong"); // [R8]
   // power stage 2b takes the master-out pin
   property p_ps2b; // [R16]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && psc.power_stage_en_2b)
         |=> pin_oe[PIN_MOSI] && pin_out[PIN_MOSI] == $past(psc.power_stage_out_2b);
   endproperty
   a_ps2b: assert property (p_ps2b) else $error("pin 1 not driven by 2b"); // [R16]
   // relocated spi leaves the serial clock pin to the registers
   property p_relocated; // [R24]
      @(posedge core_clk) disable iff (!resetn)
      (resetn && spi_ctl.spi_pin_relocate && !psc.power_stage_en_0b)
         |=> pin_oe[PIN_SCK] == $past(dir_bits[PIN_SCK])
             && pin_out[PIN_SCK] == $past(out_bits[PIN_SCK]);
   endproperty
   a_relocated: assert property (p_relocated) else $error("relocated spi touched sck"); // [R24]
endmodule : pbmux_top
`default_nettype wire

// file: pbmux_periph_model.sv
// peripheral stand-in: spi, power stage, irq and analog controls from one word.
// assumes the bench changes the word just after a rising core_clk edge.
`timescale 1ns/10ps
`default_nettype none
module pbmux_periph_model (
   input  wire logic [23:0]      cmd,        // packed peripheral state
   output pbmux_pkg::pbmux_spi_s spi_ctl,    // spi mode bits
   output pbmux_pkg::pbmux_psc_s psc,        // power stage outputs
   output logic      [2:0]       spi_outs,   // sck, mosi, miso drive
   output logic      [1:0]       irq_en,     // irq 2, irq 1 enables
   output logic      [7:0]       analog_dis  // analog input disables
);
   import pbmux_pkg::*;
   // plain decode, so peripheral state lands with the bench's own edge
   always_comb begin
      spi_ctl = pbmux_spi_s'({cmd[0], cmd[1], cmd[2]});
      psc = pbmux_psc_s'(cmd[10:3]);
      spi_outs = {cmd[11], cmd[12], cmd[13]};
      irq_en = cmd[15:14];
      // spi data pins carry no analog channel
      analog_dis = {cmd[23:18], 2'b00};
   end
endmodule : pbmux_periph_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the port b mux: corner table plus seeded random.
// assumes the peripheral stand-in and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pbmux_pkg::*;
   logic core_clk = 1'b0, resetn = 1'b0;              // clock and reset
   logic [7:0] dir_bits = 8'h00, out_bits = 8'h00, pin_in = 8'h00; // port side
   logic global_pullup_off = 1'b0, sleep_clamp = 1'b0, internal_reset = 1'b0;
   logic [23:0] cmd = 24'h000000;                     // peripheral word
   pbmux_spi_s spi_ctl;                                // from stand-in
   pbmux_psc_s psc;
   logic [2:0] spi_outs;
   logic [1:0] irq_en;
   logic [7:0] analog_dis, pin_out, pin_oe, pin_pullup, pin_input_on, pin_change_irq;
   logic ext_irq_1, ext_irq_2, spi_sck_in, spi_mosi_in, spi_miso_in;
   int mismatches = 0, n_checks = 0, seed = 32'h1A78;
   localparam logic [23:0] CORNER [6] = '{24'h000001, 24'h003803, 24'h002805,
                                          24'h0007F9, 24'hFCC000, 24'hFC0000};

   always #4 core_clk = ~core_clk;  // 125 MHz

   pbmux_periph_model peri (.cmd(cmd), .spi_ctl(spi_ctl), .psc(psc), .spi_outs(spi_outs),
                            .irq_en(irq_en), .analog_dis(analog_dis));
   pbmux_top uut (.core_clk(core_clk), .resetn(resetn), .dir_bits(dir_bits),
      .out_bits(out_bits), .global_pullup_off(global_pullup_off), .sleep_clamp(sleep_clamp),
      .internal_reset(internal_reset), .spi_ctl(spi_ctl), .psc(psc),
      .spi_sck_out(spi_outs[2]), .spi_mosi_out(spi_outs[1]), .spi_miso_out(spi_outs[0]),
      .ext_irq_1_enabled(irq_en[0]), .ext_irq_2_enabled(irq_en[1]),
      .analog_in_disable(analog_dis), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .pin_input_on(pin_input_on), .pin_change_irq(pin_change_irq),
      .ext_irq_1(ext_irq_1), .ext_irq_2(ext_irq_2), .spi_sck_in(spi_sck_in),
      .spi_mosi_in(spi_mosi_in), .spi_miso_in(spi_miso_in));

   // expected pad controls worked out from the peripheral word
   function automatic pbmux_pad_s exp_pad();
      pbmux_pad_s e;
      logic slv, mas;
      slv = cmd[0] & ~cmd[1] & ~cmd[2];  // relocation drops spi overrides
      mas = cmd[0] & cmd[1] & ~cmd[2];
      e.drive_en = dir_bits;
      e.drive_val = out_bits;
      if (slv) begin
         e.drive_en[7] = 1'b0;
         e.drive_en[1] = 1'b0;
         e.drive_val[0] = cmd[13];
      end
      if (mas) begin
         e.drive_en[0] = 1'b0;
         e.drive_val[7] = cmd[11];
         e.drive_val[1] = cmd[12];
      end
      e.pullup_on = ~e.drive_en & out_bits & {8{~global_pullup_off}};
      if (cmd[10]) {e.drive_en[7], e.drive_val[7]} = {1'b1, cmd[9]};
      if (cmd[8]) {e.drive_en[6], e.drive_val[6]} = {1'b1, cmd[7]};
      if (cmd[6]) {e.drive_en[1], e.drive_val[1]} = {1'b1, cmd[5]};
      if (cmd[4]) {e.drive_en[0], e.drive_val[0]} = {1'b1, cmd[3]};
      e.input_on = ~{cmd[23:18], 2'b00} & {8{~sleep_clamp}};
      if (cmd[14]) e.input_on[2] = 1'b1;
      if (cmd[15]) e.input_on[5] = 1'b1;
      return e;
   endfunction : exp_pad

   // pull-ups of pins taken by the power stage are left unjudged
   function automatic logic [7:0] pu_mask();
      return ~{cmd[10], cmd[8], 4'h0, cmd[6], cmd[4]};
   endfunction : pu_mask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_pads(input pbmux_pad_s e);
      check(pin_oe, e.drive_en);
      check(pin_out & e.drive_en, e.drive_val & e.drive_en);
      check(pin_pullup & pu_mask(), e.pullup_on & pu_mask());
      check(pin_input_on, e.input_on);
   endtask : check_pads

   // one setting: pads checked one edge later, input paths once settled
   task automatic apply(input logic [23:0] c, input logic [7:0] d, o, p,
                        input logic [2:0] m);
      pbmux_pad_s e;
      logic [7:0] g;
      @(posedge core_clk);
      cmd <= c;
      dir_bits <= d;
      out_bits <= o;
      pin_in <= p;
      {global_pullup_off, sleep_clamp, internal_reset} <= m;
      @(posedge core_clk);
      #1;
      e = exp_pad();
      check_pads(e);
      repeat (7) @(posedge core_clk);
      #1;
      check_pads(e);
      g = pin_in & e.input_on;
      check(pin_change_irq, g);
      check({6'h00, ext_irq_2, ext_irq_1}, {6'h00, g[5], g[2]});
      check({5'h00, spi_sck_in, spi_mosi_in, spi_miso_in},
            {5'h00, {g[7], g[1], g[0]} & {3{~cmd[2] & ~internal_reset}}});
   endtask : apply

   // reset holds every pad control low
   task automatic reset_check();
      @(posedge core_clk);
      resetn <= 1'b0;
      @(posedge core_clk);
      #1;
      check(pin_oe | pin_pullup | pin_input_on, 8'h00);
      check(pin_out | pin_change_irq | {2'h0, ext_irq_1, ext_irq_2, spi_sck_in, spi_mosi_in,
            spi_miso_in, 1'b0}, 8'h00);
      @(posedge core_clk);
      resetn <= 1'b1;
   endtask : reset_check

   task automatic summarize();
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // watchdog well beyond the expected few thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      summarize();
   end

   // main sequence: reset, corner table, random, reset mid-run, random
   initial begin
      reset_check();
      foreach (CORNER[i]) begin
         for (int m = 0; m < 8; m++) begin
            apply(CORNER[i], 8'hFF, 8'hFF, 8'hFF, 3'(m));
            apply(CORNER[i], 8'h00, 8'hFF, 8'hA5, 3'(m));
         end
      end
      apply(24'hFC0000, 8'h00, 8'h00, 8'hFF, 3'h0);
      for (int k = 0; k < 300; k++) begin
         if (k == 150) reset_check();
         apply(24'($random(seed)), 8'($random(seed)), 8'($random(seed)),
               8'($random(seed)), 3'($random(seed)));
      end
      summarize();
   end
endmodule : testbench
`default_nettype wire
